//--- hdl/ssp_pkg.sv
// Purpose: shared constants and carriers for the self-test, strap status
//          and pulldown register slice
// Assumes: 8-bit register words addressed by 8-bit offsets
// Notes:   register port is a simple synchronous read/write strobe port
package ssp_pkg;
    // register offsets
    localparam logic [7:0] SSP_SELFTEST_OFS = 8'hB3;
    localparam logic [7:0] SSP_STRAP_OFS = 8'hB8;
    localparam logic [7:0] SSP_PULLDOWN_OFS = 8'hBE;
    // remote serializer clock source register offset
    localparam logic [7:0] SSP_REMOTE_CLK_OFS = 8'h14;
    // selftest control field positions
    localparam int SSP_EN_BIT = 0;
    localparam int SSP_CLKSEL_LO = 1;
    localparam int SSP_CFGPIN_BIT = 3;
    // strap status field positions
    localparam int SSP_MODE_LO = 0;
    localparam int SSP_MODE_DONE_BIT = 3;
    localparam int SSP_IDX_LO = 4;
    localparam int SSP_INDEX_STRAP_LATCHED_BIT = 7;
    // reset values
    localparam logic [7:0] SSP_SELFTEST_RST = 8'h08;
    localparam logic [7:0] SSP_PULLDOWN_RST = 8'h00;
    localparam logic [2:0] SSP_PULLDOWN_MASK = 3'h7;
    // cycles the strap decoder is given after reset release
    localparam int SSP_STRAP_SETTLE_CYC = 16;

    // register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssp_req_type;

    // back-channel write toward the remote serializer
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } ssp_remote_wr_type;
endpackage : ssp_pkg

//--- hdl/ssp_strap_latch.sv
// Purpose: captures one 3-bit strap decode once after reset release
// Assumes: decoded strap value is steady during the settle window
// Notes:   value holds until the next reset
`timescale 1ns/10ps
module ssp_strap_latch
    import ssp_pkg::*;
#(
    parameter int SETTLE = SSP_STRAP_SETTLE_CYC
)
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] decode_in,
    output logic [2:0] value_out,
    output logic done_out
);
    // settle counter, runs only until capture
    logic [7:0] cnt_r;

    // capture after settle; later reads cannot disturb the value
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_r <= 8'h00;
            value_out <= 3'h0;
            done_out <= 1'b0;
        end
        else if (!done_out)
        begin
            if (cnt_r == 8'(SETTLE - 1))
            begin
                value_out <= decode_in;
                done_out <= 1'b1;
            end
            else
            begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule : ssp_strap_latch

//--- hdl/ssp_regs.sv
// Purpose: self-test control tail, strap decode status and pin pulldown
//          control registers
// Assumes: register port strobes are one cycle wide and synchronous
// Notes:   read data is registered, one cycle after the read strobe;
//          strap status reads zero until the settle window has run;
//          the self-test byte is kept whole, so bits 7:4 read back
`timescale 1ns/10ps
module ssp_regs
    import ssp_pkg::*;
#(
    parameter int NPINS = 3,
    parameter int SETTLE = SSP_STRAP_SETTLE_CYC
)
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire ssp_req_type req_in,
    input wire logic [2:0] index_strap_decode_in,
    input wire logic [2:0] mode_strap_decode_in,
    input wire logic strap_selftest_enable_in,
    input wire logic [1:0] strap_clock_select_in,
    input wire logic [NPINS-1:0] pin_output_mode_in,
    output logic [7:0] rdata_out,
    output logic selftest_active_out,
    output logic [1:0] selftest_clock_out,
    output ssp_remote_wr_type remote_wr_out,
    output logic [NPINS-1:0] pulldown_on_out
);
    // stored self-test control byte
    // bit 3 resets high, so the straps steer self-test after power-up
    logic [7:0] selftest_r;
    // pulldown disable bits
    // sized by NPINS; more than eight pins would need a second register
    logic [NPINS-1:0] pin_pulldown_control_r;
    // latched strap values and done flags
    logic [2:0] index_strap_value;
    logic [2:0] mode_strap_value;
    logic index_strap_latched;
    logic mode_strap_latched;
    // effective enable and select, picked by config source
    logic eff_en;
    logic [1:0] eff_sel;
    // previous effective enable, for rising edge
    // resets low, so an enable already set by strap forwards once
    logic eff_en_r;
    // next read word, chosen by address
    logic [7:0] rdata_nxt;

    // both straps share one settle time, so their done flags rise together
    // the counter inside stops once done, so it cannot wrap and recapture
    // index strap capture
    ssp_strap_latch #(.SETTLE(SETTLE)) u_index
    (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .decode_in(index_strap_decode_in),
        .value_out(index_strap_value),
        .done_out(index_strap_latched)
    );

    // mode strap capture
    ssp_strap_latch #(.SETTLE(SETTLE)) u_mode
    (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .decode_in(mode_strap_decode_in),
        .value_out(mode_strap_value),
        .done_out(mode_strap_latched)
    );

    // self-test control writes
    // the whole byte is kept; only bits 3:0 steer logic in this slice
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            selftest_r <= SSP_SELFTEST_RST;
        end
        else if (req_in.wr && req_in.addr == SSP_SELFTEST_OFS)
        begin
            selftest_r <= req_in.wdata;
        end
    end

    // pulldown control writes; reserved bits are not stored
    // dropping bits 7:3 here keeps them reading zero without a mask
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // every automatic pulldown starts enabled
            pin_pulldown_control_r <= NPINS'(SSP_PULLDOWN_RST);
        end
        else if (req_in.wr && req_in.addr == SSP_PULLDOWN_OFS)
        begin
            pin_pulldown_control_r <= req_in.wdata[NPINS-1:0];
        end
    end

    // source select between register fields and strap pins
    // flipping the source while enabled can raise eff_en and forward
    always_comb
    begin
        if (selftest_r[SSP_CFGPIN_BIT])
        begin
            // strap pins steer self-test
            eff_en = strap_selftest_enable_in;
            eff_sel = strap_clock_select_in;
        end
        else
        begin
            // register fields steer self-test
            eff_en = selftest_r[SSP_EN_BIT];
            eff_sel = selftest_r[SSP_CLKSEL_LO +: 2];
        end
    end

    // self-test outputs and forwarding to remote serializer
    // a select change while enabled is not sent again; toggle the
    // enable to resend, which keeps the back channel quiet otherwise
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // self-test off and nothing forwarded while in reset
            eff_en_r <= 1'b0;
            selftest_active_out <= 1'b0;
            selftest_clock_out <= 2'h0;
            remote_wr_out <= '0;
        end
        else
        begin
            // edge memory; a level that stays high forwards only once
            eff_en_r <= eff_en;
            selftest_active_out <= eff_en;
            selftest_clock_out <= eff_sel;
            // forward on enable; value 3 is not blocked
            remote_wr_out.valid <= eff_en && !eff_en_r;
            remote_wr_out.addr <= SSP_REMOTE_CLK_OFS;
            remote_wr_out.data <= {6'h00, eff_sel};
        end
    end

    // pulldown drive per pin
    // output pins never pull down, whatever their disable bit says
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // no pulldown until the first edge after reset
            pulldown_on_out <= '0;
        end
        else
        begin
            pulldown_on_out <= ~pin_output_mode_in & ~pin_pulldown_control_r;
        end
    end

    // read mux; reads change no state
    // offsets are distinct; the default catches every unmapped one
    always_comb
    begin
        // zero word unless an offset below says otherwise
        rdata_nxt = 8'h00;
        unique case (req_in.addr)
            // self-test byte reads back as written
            SSP_SELFTEST_OFS:
                rdata_nxt = selftest_r;
            SSP_STRAP_OFS:
            begin
                rdata_nxt[SSP_INDEX_STRAP_LATCHED_BIT] = index_strap_latched;
                rdata_nxt[SSP_IDX_LO +: 3] = index_strap_value;
                rdata_nxt[SSP_MODE_DONE_BIT] = mode_strap_latched;
                rdata_nxt[SSP_MODE_LO +: 3] = mode_strap_value;
            end
            // reserved bits 7:3 stay zero from the line above
            SSP_PULLDOWN_OFS:
                rdata_nxt[NPINS-1:0] = pin_pulldown_control_r;
            // unmapped offsets read zero
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    // registered read data
    // only a read strobe loads the word; it holds until the next read,
    // so a slow master may sample it late
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_out <= 8'h00;
        end
        else if (req_in.rd)
        begin
            rdata_out <= rdata_nxt;
        end
    end
endmodule : ssp_regs

//--- testbench/ssp_regs_chk_assertions.sv
// Purpose: port checks for the self-test, strap and pulldown slice
// Assumes: one clock, async active-low reset
// Notes: ctl_r shadows writes to the self-test register
`timescale 1ns/10ps
module ssp_regs_chk
    import ssp_pkg::*;
#(
    parameter int NPINS = 3
)
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire ssp_req_type req_in,
    input wire logic strap_selftest_enable_in,
    input wire logic [1:0] strap_clock_select_in,
    input wire logic [NPINS-1:0] pin_output_mode_in,
    input wire logic [7:0] rdata_out,
    input wire logic selftest_active_out,
    input wire logic [1:0] selftest_clock_out,
    input wire ssp_remote_wr_type remote_wr_out,
    input wire logic [NPINS-1:0] pulldown_on_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] ctl_r; // shadow copy, reset has pin config set
    // track software writes so the source can be predicted
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ctl_r <= 8'h08;
        else if (req_in.wr && req_in.addr == SSP_SELFTEST_OFS)
            ctl_r <= req_in.wdata;
    end
    // three steady cycles cover either source latency
    sequence s_reg_steady;
        (!ctl_r[3] && $stable(ctl_r))[*3];
    endsequence
    sequence s_pin_steady;
        (ctl_r[3] && strap_selftest_enable_in
            && $stable(strap_clock_select_in))[*3];
    endsequence
    AST_REG_EN: assert property (s_reg_steady |->
        selftest_active_out == ctl_r[0]) else $error("enable wrong");
    AST_REG_CLK: assert property (s_reg_steady |->
        selftest_clock_out == ctl_r[2:1]) else $error("clock wrong");
    AST_PIN_SRC: assert property (s_pin_steady |->
        selftest_active_out && selftest_clock_out == strap_clock_select_in)
        else $error("pin source ignored");
    AST_FWD_DATA: assert property (remote_wr_out.valid |->
        remote_wr_out.addr == 8'h14 &&
        remote_wr_out.data == {6'h00, selftest_clock_out})
        else $error("forward content wrong");
    AST_FWD_RISE: assert property ($rose(selftest_active_out)
        |-> remote_wr_out.valid) else $error("forward missing");
    AST_FWD_PULSE: assert property (remote_wr_out.valid |=>
        !remote_wr_out.valid) else $error("forward too long");
    AST_PULLDOWN: assert property (
        (pulldown_on_out & $past(pin_output_mode_in)) == '0)
        else $error("pulldown on output pin");
    AST_RESERVED: assert property (req_in.rd &&
        req_in.addr == 8'hBE |=> rdata_out[7:3] == 5'h00)
        else $error("reserved bits set");
    AST_RDATA_HOLD: assert property (!req_in.rd |=>
        $stable(rdata_out)) else $error("read data moved");
endmodule : ssp_regs_chk
bind ssp_regs ssp_regs_chk #(.NPINS(NPINS)) chk (.mclk_in, .rst_n_in,
    .req_in, .strap_selftest_enable_in, .strap_clock_select_in,
    .pin_output_mode_in, .rdata_out, .selftest_active_out,
    .selftest_clock_out, .remote_wr_out, .pulldown_on_out);

//--- testbench/ssp_remote_model.sv
// Purpose: remote serializer end of the back-channel writes
// Assumes: writes arrive as one-cycle valid pulses
// Notes: only the clock source register is modelled
`timescale 1ns/10ps
module ssp_remote_model
    import ssp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire ssp_remote_wr_type wr_in,
    output logic [1:0] clk_src_out,
    output logic [7:0] wr_count_out
);
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            {clk_src_out, wr_count_out} <= 10'h000;
        else if (wr_in.valid && wr_in.addr == 8'h14)
            {clk_src_out, wr_count_out} <=
                {wr_in.data[1:0], wr_count_out + 8'h01};
    end
endmodule : ssp_remote_model

//--- testbench/testbench.sv
// Purpose: directed checks of the self-test, strap and pulldown slice
// Assumes: 125 MHz clock, shortened strap settle time
// Notes: remote model counts forwarded writes
`timescale 1ns/10ps
module testbench;
    import ssp_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    ssp_req_type req_in = '0;
    logic [2:0] idx_dec = 3'h5, mode_dec = 3'h2, out_mode = 3'h0, pd_on;
    logic st_en = 1'b0, active;
    logic [1:0] st_clk = 2'h0, clk_sel, rem_src;
    logic [7:0] rdata, rem_cnt, got;
    ssp_remote_wr_type fwd;
    int bad_count = 0, checked = 0;
    ssp_regs #(.SETTLE(4)) uut (.mclk_in, .rst_n_in, .req_in,
        .index_strap_decode_in(idx_dec), .mode_strap_decode_in(mode_dec),
        .strap_selftest_enable_in(st_en), .strap_clock_select_in(st_clk),
        .pin_output_mode_in(out_mode), .rdata_out(rdata),
        .selftest_active_out(active), .selftest_clock_out(clk_sel),
        .remote_wr_out(fwd), .pulldown_on_out(pd_on));
    ssp_remote_model peer (.mclk_in, .rst_n_in, .wr_in(fwd),
        .clk_src_out(rem_src), .wr_count_out(rem_cnt));
    initial forever #4 mclk_in = ~mclk_in;
    task automatic compare(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : compare
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in) req_in <= '{1'b1, 1'b0, a, d};
        @(posedge mclk_in) req_in <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_in) req_in <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk_in) req_in <= '0;
        @(posedge mclk_in) #1 got = rdata;
    endtask : rd
    task automatic settle(); // let registered outputs land
        repeat (4) @(posedge mclk_in);
        #1;
    endtask : settle
    task automatic t_reset_strap();
        rd(SSP_SELFTEST_OFS);
        compare(got, 8'h08);
        compare({5'h00, pd_on}, 8'h07);
        rd(SSP_STRAP_OFS);
        compare(got, 8'hDA);
        @(posedge mclk_in) {idx_dec, mode_dec} <= 6'h0F;
        rd(SSP_STRAP_OFS);
        rd(SSP_STRAP_OFS);
        compare(got, 8'hDA);
        $display("reset and strap test done");
    endtask : t_reset_strap
    task automatic t_selftest();
        @(posedge mclk_in) {st_en, st_clk} <= 3'h6;
        settle();
        compare({5'h00, active, clk_sel}, 8'h06);
        compare({6'h00, rem_src}, 8'h02);
        @(posedge mclk_in) st_en <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            wr(SSP_SELFTEST_OFS, 8'(k * 2 + 1));
            settle();
            compare({5'h00, active, clk_sel}, 8'(4 + k));
            compare({6'h00, rem_src}, 8'(k));
            wr(SSP_SELFTEST_OFS, 8'h00);
        end
        @(posedge mclk_in) st_en <= 1'b1;
        settle();
        compare({7'h00, active}, 8'h00);
        compare(rem_cnt, 8'h05);
        $display("self-test forward test done");
    endtask : t_selftest
    task automatic t_pulldown();
        @(posedge mclk_in) out_mode <= 3'h1;
        wr(SSP_PULLDOWN_OFS, 8'hFA);
        rd(SSP_PULLDOWN_OFS);
        compare(got, 8'h02);
        compare({5'h00, pd_on}, 8'h04);
        rd(8'h55);
        compare(got, 8'h00);
        $display("pulldown test done");
    endtask : t_pulldown
    task automatic t_rereset(); // mid-run reset relatches the straps
        @(posedge mclk_in) rst_n_in <= 1'b0;
        @(posedge mclk_in) rst_n_in <= 1'b1;
        settle();
        rd(SSP_STRAP_OFS);
        compare(got, 8'h9F);
        rd(SSP_PULLDOWN_OFS);
        compare(got, 8'h00);
        compare({5'h00, pd_on}, 8'h06);
        compare({5'h00, active, clk_sel}, 8'h06);
        compare({6'h00, rem_src}, 8'h02);
        compare(rem_cnt, 8'h01);
        $display("mid-run reset test done");
    endtask : t_rereset
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (4) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        t_reset_strap();
        t_selftest();
        t_pulldown();
        t_rereset();
        test_done();
    end
    initial
    begin
        #20000;
        bad_count++;
        test_done();
    end
endmodule : testbench
